// *** hdl/adcsp_defs.svh ***
`ifndef ADCSP_DEFS_SVH
`define ADCSP_DEFS_SVH

// Register select codes
`define ADCSP_RS_STATUS    3'h0
`define ADCSP_RS_MODE      3'h1
`define ADCSP_RS_CONFIG    3'h2
`define ADCSP_RS_DATA      3'h3
`define ADCSP_RS_ID        3'h4
`define ADCSP_RS_IO        3'h5
`define ADCSP_RS_OFFSET    3'h6
`define ADCSP_RS_FULLSCALE 3'h7

// Communication byte fields
`define ADCSP_COMM_WEN_N   7
`define ADCSP_COMM_READ    6
`define ADCSP_COMM_RS_HI   5
`define ADCSP_COMM_RS_LO   3

// Reset values
`define ADCSP_MODE_RST     16'h000a
`define ADCSP_CONFIG_RST   16'h0710
`define ADCSP_IO_RST       8'h00
`define ADCSP_OFFSET_RST   24'h800000
`define ADCSP_FS_RST       24'h500000
// Identity code, value arbitrary
`define ADCSP_ID_VALUE     8'h5a

// Ready level stays high this many cycles plus one before an unread result is replaced
`define ADCSP_RDY_GAP_CYC  4'hf

`endif

// *** hdl/adcsp_pkg.sv ***
package adcsp_pkg;

  typedef enum logic [1:0] {
    PH_COMM,
    PH_WRITE,
    PH_READ
  } adcsp_phase_t;

  typedef struct packed {
    logic [15:0] mode;
    logic [15:0] config_w;
    logic [7:0]  io;
    logic [23:0] offset;
    logic [23:0] fullscale;
  } adcsp_cfg_t;

endpackage : adcsp_pkg

// *** hdl/adcsp_serial_port.sv ***
`include "adcsp_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module adcsp_serial_port (
  input  wire logic               clk,        // System clock, 20 MHz
  input  wire logic               reset,      // Synchronous, active high
  input  wire logic               sclk,       // Serial clock pin from host
  input  wire logic               cs_n,       // Device select pin, active low
  input  wire logic               din,        // Serial data input pin
  input  wire logic [23:0]        conv_data,  // New conversion result
  input  wire logic               conv_valid, // Result offered
  output logic                    conv_ready, // Result buffer has room
  output logic                    dout_rdy,   // Serial data out / ready level
  output logic                    dout_oe,    // Pin driven while selected
  output var adcsp_pkg::adcsp_cfg_t cfg       // Written control registers
);

  logic [2:0] sclk_sync;
  logic [1:0] cs_sync;
  logic [1:0] din_sync;

  adcsp_pkg::adcsp_phase_t phase, next_phase;
  logic [4:0]  cnt, next_cnt;
  logic [2:0]  rs, next_rs;
  logic [22:0] in_sr, next_in_sr;
  logic [23:0] out_sr, next_out_sr;
  logic        next_dout_rdy;
  logic        next_dout_oe;
  logic        rdy_n, next_rdy_n;
  logic [3:0]  gap, next_gap;
  logic [23:0] data, next_data;
  adcsp_pkg::adcsp_cfg_t next_cfg;
  logic [23:0] buf_mem [2];
  logic [23:0] next_buf0, next_buf1;
  logic        wr_ptr, next_wr_ptr;
  logic        rd_ptr, next_rd_ptr;
  logic [1:0]  fill, next_fill;
  logic        next_conv_ready;

  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_idle;
  logic        din_s;

  function automatic logic [4:0] reg_width(input logic [2:0] sel);
    unique case (sel)
      `ADCSP_RS_STATUS, `ADCSP_RS_ID, `ADCSP_RS_IO: reg_width = 5'h08;
      `ADCSP_RS_MODE, `ADCSP_RS_CONFIG:            reg_width = 5'h10;
      default:                                     reg_width = 5'h18;
    endcase
  endfunction : reg_width

  function automatic logic writable(input logic [2:0] sel);
    writable = !(sel == `ADCSP_RS_STATUS || sel == `ADCSP_RS_DATA || sel == `ADCSP_RS_ID);
  endfunction : writable

  // Only the second stage is read; the third holds the previous level for edges
  assign sclk_rise = sclk_sync[1] & ~sclk_sync[2];
  assign sclk_fall = ~sclk_sync[1] & sclk_sync[2];
  assign cs_idle   = cs_sync[1];
  assign din_s     = din_sync[1];

  always_comb begin
    logic [23:0] word;
    logic [7:0]  cmd;
    logic        reading_data;
    logic        push;
    logic        pop;
    word          = {in_sr, din_s};
    cmd           = word[7:0];
    reading_data  = (phase == adcsp_pkg::PH_READ) && (rs == `ADCSP_RS_DATA);
    push          = conv_valid & conv_ready;
    pop           = 1'b0;
    next_phase    = phase;
    next_cnt      = cnt;
    next_rs       = rs;
    next_in_sr    = in_sr;
    next_out_sr   = out_sr;
    next_dout_rdy = dout_rdy;
    next_rdy_n    = rdy_n;
    next_gap      = gap;
    next_data     = data;
    next_cfg      = cfg;
    next_wr_ptr   = wr_ptr;
    next_rd_ptr   = rd_ptr;
    next_buf0     = buf_mem[0];
    next_buf1     = buf_mem[1];
    next_dout_oe  = ~cs_idle;

    if (cs_idle) begin
      // Deselect aborts any partial transfer; next byte is a command again
      next_phase = adcsp_pkg::PH_COMM;
      next_cnt   = 5'h00;
    end else if (sclk_rise) begin
      next_in_sr = word[22:0];
      next_cnt   = cnt + 5'h01;
      unique case (phase)
        adcsp_pkg::PH_COMM: begin
          if (cnt == 5'h07) begin
            next_cnt = 5'h00;
            if (!cmd[`ADCSP_COMM_WEN_N]) begin
              next_rs = cmd[`ADCSP_COMM_RS_HI:`ADCSP_COMM_RS_LO];
              if (cmd[`ADCSP_COMM_READ]) begin
                next_phase = adcsp_pkg::PH_READ;
                // Left-align so the MSB always leaves first
                unique case (next_rs)
                  `ADCSP_RS_STATUS:    next_out_sr = {rdy_n, 23'h000000};
                  `ADCSP_RS_MODE:      next_out_sr = {cfg.mode, 8'h00};
                  `ADCSP_RS_CONFIG:    next_out_sr = {cfg.config_w, 8'h00};
                  `ADCSP_RS_DATA:      next_out_sr = data;
                  `ADCSP_RS_ID:        next_out_sr = {`ADCSP_ID_VALUE, 16'h0000};
                  `ADCSP_RS_IO:        next_out_sr = {cfg.io, 16'h0000};
                  `ADCSP_RS_OFFSET:    next_out_sr = cfg.offset;
                  `ADCSP_RS_FULLSCALE: next_out_sr = cfg.fullscale;
                endcase
              end else if (writable(next_rs)) begin
                next_phase = adcsp_pkg::PH_WRITE;
              end
            end
          end
        end
        adcsp_pkg::PH_WRITE: begin
          if (cnt == reg_width(rs) - 5'h01) begin
            next_phase = adcsp_pkg::PH_COMM;
            next_cnt   = 5'h00;
            unique case (rs)
              `ADCSP_RS_MODE:      next_cfg.mode      = word[15:0];
              `ADCSP_RS_CONFIG:    next_cfg.config_w  = word[15:0];
              `ADCSP_RS_IO:        next_cfg.io        = word[7:0];
              `ADCSP_RS_OFFSET:    next_cfg.offset    = word;
              `ADCSP_RS_FULLSCALE: next_cfg.fullscale = word;
              default:             next_cfg           = cfg;
            endcase
          end
        end
        adcsp_pkg::PH_READ: begin
          if (cnt == reg_width(rs) - 5'h01) begin
            next_phase = adcsp_pkg::PH_COMM;
            next_cnt   = 5'h00;
            if (rs == `ADCSP_RS_DATA) begin
              next_rdy_n = 1'b1;
            end
          end
        end
        default: begin
          next_phase = adcsp_pkg::PH_COMM;
          next_cnt   = 5'h00;
        end
      endcase
    end else if (sclk_fall && phase == adcsp_pkg::PH_READ) begin
      next_dout_rdy = out_sr[23];
      next_out_sr   = {out_sr[22:0], 1'b0};
    end

    // Outside a read the pin shows the ready level
    if (next_phase != adcsp_pkg::PH_READ) begin
      next_dout_rdy = next_rdy_n;
    end

    // Result update stalls while the data register is being shifted out
    if (fill != 2'h0 && !reading_data) begin
      if (!rdy_n) begin
        next_rdy_n = 1'b1;
        next_gap   = `ADCSP_RDY_GAP_CYC;
      end else if (gap != 4'h0) begin
        next_gap = gap - 4'h1;
      end else begin
        pop         = 1'b1;
        next_data   = buf_mem[rd_ptr];
        next_rd_ptr = ~rd_ptr;
        next_rdy_n  = 1'b0;
        if (next_phase != adcsp_pkg::PH_READ) begin
          next_dout_rdy = 1'b0;
        end
      end
    end

    if (push) begin
      if (wr_ptr) begin
        next_buf1 = conv_data;
      end else begin
        next_buf0 = conv_data;
      end
      next_wr_ptr = ~wr_ptr;
    end
    next_fill       = fill + {1'b0, push} - {1'b0, pop};
    next_conv_ready = (next_fill != 2'h2);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      // Clock and select synchronisers load idle-high levels, so no false serial clock edge follows reset
      sclk_sync          <= 3'h7;
      cs_sync            <= 2'h3;
      din_sync           <= 2'h0;
      phase              <= adcsp_pkg::PH_COMM;
      cnt                <= 5'h00;
      rs                 <= 3'h0;
      in_sr              <= 23'h000000;
      out_sr             <= 24'h000000;
      dout_rdy           <= 1'b1;
      dout_oe            <= 1'b0;
      rdy_n              <= 1'b1;
      gap                <= 4'h0;
      data               <= 24'h000000;
      cfg.mode           <= `ADCSP_MODE_RST;
      cfg.config_w       <= `ADCSP_CONFIG_RST;
      cfg.io             <= `ADCSP_IO_RST;
      cfg.offset         <= `ADCSP_OFFSET_RST;
      cfg.fullscale      <= `ADCSP_FS_RST;
      buf_mem[0]         <= 24'h000000;
      buf_mem[1]         <= 24'h000000;
      wr_ptr             <= 1'b0;
      rd_ptr             <= 1'b0;
      fill               <= 2'h0;
      conv_ready         <= 1'b0;
    end else begin
      sclk_sync          <= {sclk_sync[1:0], sclk};
      cs_sync            <= {cs_sync[0], cs_n};
      din_sync           <= {din_sync[0], din};
      phase              <= next_phase;
      cnt                <= next_cnt;
      rs                 <= next_rs;
      in_sr              <= next_in_sr;
      out_sr             <= next_out_sr;
      dout_rdy           <= next_dout_rdy;
      dout_oe            <= next_dout_oe;
      rdy_n              <= next_rdy_n;
      gap                <= next_gap;
      data               <= next_data;
      cfg                <= next_cfg;
      buf_mem[0]         <= next_buf0;
      buf_mem[1]         <= next_buf1;
      wr_ptr             <= next_wr_ptr;
      rd_ptr             <= next_rd_ptr;
      fill               <= next_fill;
      conv_ready         <= next_conv_ready;
    end
  end

endmodule : adcsp_serial_port

`default_nettype wire

// *** verification/adcsp_serial_port_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module adcsp_serial_port_sva (
  input wire logic                  clk,        // System clock
  input wire logic                  reset,      // Sync reset
  input wire logic                  sclk,       // Serial clock
  input wire logic                  cs_n,       // Select
  input wire logic                  din,        // Serial in
  input wire logic [23:0]           conv_data,  // Result
  input wire logic                  conv_valid, // Result offered
  input wire logic                  conv_ready, // Buffer room
  input wire logic                  dout_rdy,   // Data out or ready
  input wire logic                  dout_oe,    // Pin driven
  input wire adcsp_pkg::adcsp_cfg_t cfg         // Control registers
);
  logic [4:0] hi_cnt;
  logic [4:0] next_hi_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // A long high run means no unread result and no gap pending
  always_comb next_hi_cnt = (reset || !dout_rdy) ? 5'h0 : (hi_cnt == 5'h1f) ? hi_cnt : hi_cnt + 5'h1;
  always_ff @(posedge clk) hi_cnt <= next_hi_cnt;
  sequence s_idle_take;
    conv_valid && conv_ready && cs_n && !dout_oe;
  endsequence
  sequence s_gap;
    ##[1:3] $rose(dout_rdy) ##1 dout_rdy [*8] ##1 dout_rdy [*6] ##[1:3] !dout_rdy;
  endsequence
  a_reset_idle: assert property ($fell(reset) |-> dout_rdy && !dout_oe)
    else $error("outputs not idle after reset");
  a_sel_drives: assert property (!cs_n [*5] |-> dout_oe)
    else $error("pin not driven while selected");
  a_desel_quiet: assert property (cs_n [*5] |-> !dout_oe)
    else $error("pin driven while deselected");
  a_fresh_low: assert property (s_idle_take ##0 hi_cnt >= 5'd20 ##1 cs_n |-> ##[0:1] !dout_rdy)
    else $error("ready level not low after new result");
  a_unread_gap: assert property (s_idle_take ##0 !dout_rdy |-> s_gap)
    else $error("unread result not replaced after high gap");
  a_cfg_selected: assert property (!$stable(cfg) |-> dout_oe || $past(dout_oe))
    else $error("control register changed while deselected");
endmodule : adcsp_serial_port_sva
`default_nettype wire

// *** verification/adcsp_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module adcsp_host_model (
  input  wire logic clk,      // System clock
  input  wire logic dout_rdy, // Data out or ready level
  input  wire logic dout_oe,  // Pin driven by the device
  output var logic  sclk,     // Serial clock, idles high
  output var logic  cs_n,     // Select, active low
  output var logic  din       // Serial data in
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end
  task sel();
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : sel
  // Released data line flips so a stale bit is never mistaken for valid
  task desel();
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    din <= ~din;
    repeat (6) @(posedge clk);
  endtask : desel
  // One burst of n bits; clock stands high between bursts
  task bits(input int n, input logic [23:0] tx, output logic [23:0] rx);
    rx = 24'h0;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk);
      sclk <= 1'b0;
      din <= tx[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      @(negedge clk);
      // Released pin reads as the inverse, so a stale level is never taken as data
      rx = {rx[22:0], dout_oe ? dout_rdy : ~dout_rdy};
      repeat (3) @(posedge clk);
    end
  endtask : bits
endmodule : adcsp_host_model
`default_nettype wire

// *** verification/adcsp_serial_port_tb.sv ***
`include "adcsp_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module adcsp_serial_port_tb;
  logic                  clk, reset, sclk, cs_n, din, conv_valid, conv_ready, dout_rdy, dout_oe;
  logic [23:0]           conv_data, v;
  adcsp_pkg::adcsp_cfg_t cfg;
  int                    fails, check_count, n;
  initial clk = 1'b0;
  always #25 clk = ~clk;
  adcsp_serial_port dut_u (.clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .din(din),
    .conv_data(conv_data), .conv_valid(conv_valid), .conv_ready(conv_ready),
    .dout_rdy(dout_rdy), .dout_oe(dout_oe), .cfg(cfg));
  adcsp_host_model host_u (.clk(clk), .dout_rdy(dout_rdy), .dout_oe(dout_oe), .sclk(sclk),
    .cs_n(cs_n), .din(din));
  task end_sim();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  task chk(input string nm, input logic [87:0] seen, input logic [87:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task bound(input logic ok);
    if (!ok) begin
      fails++;
      end_sim();
    end
  endtask : bound
  function automatic logic [23:0] reg_rst(input logic [2:0] rs);
    case (rs)
      3'h1: return 24'(`ADCSP_MODE_RST);
      3'h2: return 24'(`ADCSP_CONFIG_RST);
      3'h4: return 24'(`ADCSP_ID_VALUE);
      3'h5: return 24'(`ADCSP_IO_RST);
      3'h6: return `ADCSP_OFFSET_RST;
      3'h7: return `ADCSP_FS_RST;
      default: return 24'h80;
    endcase
  endfunction : reg_rst
  task rd(input logic [2:0] rs, output logic [23:0] val);
    logic [23:0] junk;
    host_u.sel();
    host_u.bits(8, {16'h0, 2'b01, rs, 3'b000}, junk);
    host_u.bits((rs == 3'h1 || rs == 3'h2) ? 16 : (rs[2:1] == 2'b11 || rs == 3'h3) ? 24 : 8,
      24'h0, val);
    host_u.desel();
  endtask : rd
  // Extra edge first so back-to-back offers never drive valid twice in a step
  task offer(input logic [23:0] val);
    int k;
    k = 0;
    @(posedge clk);
    conv_data <= val;
    conv_valid <= 1'b1;
    do begin
      @(negedge clk);
      k++;
    end while (conv_ready !== 1'b1 && k < 50);
    bound(k < 50);
    @(posedge clk);
    conv_valid <= 1'b0;
  endtask : offer
  task wait_rdy(input logic lvl);
    n = 0;
    while (dout_rdy !== lvl && n < 100) begin
      @(negedge clk);
      n++;
    end
    bound(n < 100);
  endtask : wait_rdy
  task t_reset();
    chk("cfg reset", cfg, {`ADCSP_MODE_RST, `ADCSP_CONFIG_RST, `ADCSP_IO_RST, `ADCSP_OFFSET_RST,
      `ADCSP_FS_RST});
    chk("ready idle", dout_rdy, 1'b1);
  endtask : t_reset
  task t_read_all();
    for (int r = 0; r < 8; r++) begin
      if (r != 3) begin
        rd(r[2:0], v);
        chk("reg read", v, reg_rst(r[2:0]));
      end
    end
  endtask : t_read_all
  // Refused command, ignored data write and an aborted word around two writes
  task t_write();
    host_u.sel();
    host_u.bits(8, 24'hc8, v);
    host_u.bits(8, 24'h08, v);
    host_u.bits(16, 24'h1234, v);
    host_u.bits(8, 24'h18, v);
    host_u.bits(8, 24'h28, v);
    host_u.bits(8, 24'h5c, v);
    host_u.desel();
    host_u.sel();
    host_u.bits(8, 24'h08, v);
    host_u.bits(4, 24'hf, v);
    host_u.desel();
    chk("mode write", cfg.mode, 16'h1234);
    chk("io write", cfg.io, 8'h5c);
    rd(3'h1, v);
    chk("mode readback", v, 24'h1234);
  endtask : t_write
  task t_conv();
    // Long idle-high run first, so the fresh-result assertion is armed
    repeat (24) @(posedge clk);
    offer(24'habcdef);
    wait_rdy(1'b0);
    chk("ready low", dout_rdy, 1'b0);
    rd(3'h0, v);
    chk("status unread", v, 24'h0);
    offer(24'h13579b);
    wait_rdy(1'b1);
    wait_rdy(1'b0);
    chk("gap length", n >= 15 && n <= 18, 1'b1);
    rd(3'h3, v);
    chk("replaced result", v, 24'h13579b);
    chk("ready after read", dout_rdy, 1'b1);
    fork
      rd(3'h3, v);
      begin
        // Offers land inside the data read, when updates stall
        repeat (120) @(posedge clk);
        offer(24'h2468ac);
        offer(24'hfedcba);
        repeat (2) @(negedge clk);
        chk("buffer full", conv_ready, 1'b0);
      end
    join
    chk("stalled read", v, 24'h13579b);
    repeat (60) @(negedge clk);
    rd(3'h3, v);
    chk("newest result", v, 24'hfedcba);
    chk("buffer drained", conv_ready, 1'b1);
  endtask : t_conv
  initial begin
    reset = 1'b1;
    conv_valid = 1'b0;
    conv_data = 24'h0;
    fails = 0;
    check_count = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (6) @(posedge clk);
    t_reset();
    t_read_all();
    t_write();
    t_conv();
    end_sim();
  end
endmodule : adcsp_serial_port_tb
bind adcsp_serial_port adcsp_serial_port_sva chk_u (.clk(clk), .reset(reset), .sclk(sclk),
  .cs_n(cs_n), .din(din), .conv_data(conv_data), .conv_valid(conv_valid),
  .conv_ready(conv_ready), .dout_rdy(dout_rdy), .dout_oe(dout_oe), .cfg(cfg));
`default_nettype wire
